/* dsf_pkg.sv */
// Constants, types and field layout of the diagnostic status flag bank.
// Assumes a register read port driven by the serial interface logic.
// Contract
// (RULE1) Low bit 0 latches a supply power-on event; a read clears it.
// (RULE2) Low bit 1 latches regulator undervoltage; a read clears it.
// (RULE3) Low bit 2 latches over-temperature shutdown; a read clears it.
// (RULE4) Low bit 3 latches over-temperature warning; a read clears it.
// (RULE5) Low bit 4 latches battery overvoltage; a read clears it.
// (RULE6) Low bit 6 latches a remote bus wakeup; a read clears it.
// (RULE7) Low bit 7 latches a watchdog timeout; a read clears it.
// (RULE8) Mid bit 0 latches transmit low over one second; a read clears it.
// (RULE9) Mid bit 1 latches temporary shutdown entry; a read clears it.
// (RULE10) Low register shows diagnostic word bits 7 to 0.
// (RULE11) Mid register shows word bits 15 to 8; bits 7 to 2 reserved.
// (RULE12) Host accepts the warning flag possibly set after a hot power-up.
// (RULE13) Registers are 8-bit slaves, reached only by host-started reads.
// (RULE14) A condition still present at the clearing read sets the flag again.
package dsf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] DSF_ADDR_LOW = 5'h08;
  localparam logic [4:0] DSF_ADDR_MID = 5'h09;
  localparam logic [7:0] DSF_RST_LOW = 8'h03;
  localparam logic [7:0] DSF_RST_MID = 8'h00;
  localparam logic [7:0] DSF_MASK_LOW = 8'hDF;
  localparam logic [7:0] DSF_MASK_MID = 8'h03;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int DSF_CLK_HZ = 100000000;
  localparam int DSF_TX_STUCK_MS = 1000;
  localparam longint DSF_TX_STUCK_CYC =
    longint'(DSF_CLK_HZ) / 1000 * DSF_TX_STUCK_MS;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic window_watchdog_timeout;
    logic remote_wakeup;
    logic battery_overvoltage;
    logic overtemp_warning;
    logic overtemp_shutdown;
    logic regulator_undervoltage;
    logic supply_por;
    logic temporary_shutdown_entry;
  } dsf_events_s;
  typedef struct packed {
    logic read_stb;
    logic [4:0] addr;
  } dsf_rd_s;
endpackage

/* dsf_flags.sv */
// Sticky, clear-on-read diagnostic flag bank, two 8-bit registers.
// Assumes detector levels arrive asynchronously and reads come from
// serial logic on core_clk as a one-cycle strobe with an address.
`timescale 1ns/1ps
module dsf_flags #(
  parameter longint TX_STUCK_CYC = dsf_pkg::DSF_TX_STUCK_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire dsf_pkg::dsf_events_s events_async,
  input wire logic transmit_low_async,
  input wire dsf_pkg::dsf_rd_s rd,
  output logic [7:0] rd_data,
  output logic rd_hit,
  output logic [15:0] diagnostic_word
);
  import dsf_pkg::*;

  // The stuck counter is 40 bits wide and must reach the limit plus one.
  if (TX_STUCK_CYC < 2 || TX_STUCK_CYC > 64'h00FF_FFFF_FFFE) begin : g_bad
    $error("TX_STUCK_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Detector levels come from analog domains; two flops each.
  dsf_events_s ev_meta_ff, ev_ff;
  logic tx_meta_ff, tx_ff;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ev_meta_ff <= '0;
      ev_ff <= '0;
      tx_meta_ff <= 1'b0;
      tx_ff <= 1'b0;
    end else begin
      ev_meta_ff <= events_async;
      ev_ff <= ev_meta_ff;
      tx_meta_ff <= transmit_low_async;
      tx_ff <= tx_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Transmit stuck timer
  // ----------------------------------------------------------------
  // Counter saturates so a line held low keeps the event asserted.
  logic [39:0] tx_cnt_ff, nxt_tx_cnt;
  logic tx_stuck;
  always_comb begin
    nxt_tx_cnt = tx_cnt_ff;
    if (!tx_ff) begin
      nxt_tx_cnt = '0;
    end else if (tx_cnt_ff <= 40'(TX_STUCK_CYC)) begin
      nxt_tx_cnt = tx_cnt_ff + 40'h1;
    end
  end
  assign tx_stuck = tx_cnt_ff > 40'(TX_STUCK_CYC); // see (RULE8)
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_cnt_ff <= '0;
    end else begin
      tx_cnt_ff <= nxt_tx_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Flag registers
  // ----------------------------------------------------------------
  logic [7:0] low_ff, nxt_low, mid_ff, nxt_mid;
  logic [7:0] set_low, set_mid, nxt_rd_data;
  logic rd_low, rd_mid, rd_data_en;
  logic [7:0] rd_data_ff;

  // Address decode shared by both registers.
  function automatic logic addr_hit(input dsf_rd_s r, input logic [4:0] a);
    return r.read_stb && (r.addr == a);
  endfunction

  always_comb begin
    set_low = 8'h00;
    set_low[0] = ev_ff.supply_por; // see (RULE1)
    set_low[1] = ev_ff.regulator_undervoltage; // see (RULE2)
    set_low[2] = ev_ff.overtemp_shutdown; // see (RULE3)
    set_low[3] = ev_ff.overtemp_warning; // see (RULE4) (RULE12)
    set_low[4] = ev_ff.battery_overvoltage; // see (RULE5)
    set_low[6] = ev_ff.remote_wakeup; // see (RULE6)
    set_low[7] = ev_ff.window_watchdog_timeout; // see (RULE7)
    set_mid = 8'h00;
    set_mid[0] = tx_stuck; // see (RULE8)
    set_mid[1] = ev_ff.temporary_shutdown_entry; // see (RULE9)
    rd_low = addr_hit(rd, DSF_ADDR_LOW); // see (RULE13)
    rd_mid = addr_hit(rd, DSF_ADDR_MID);
    rd_data_en = rd_low || rd_mid;
    // Refused reads leave the last answer standing for the host.
    nxt_rd_data = rd_data_ff;
    if (rd_data_en) begin
      nxt_rd_data = rd_low ? low_ff : mid_ff;
    end
    // Set beats the read clear, so a live condition reappears at once.
    nxt_low = (rd_low ? 8'h00 : low_ff) | set_low; // see (RULE14)
    nxt_low = nxt_low & DSF_MASK_LOW;
    nxt_mid = (rd_mid ? 8'h00 : mid_ff) | set_mid;
    nxt_mid = nxt_mid & DSF_MASK_MID; // see (RULE11)
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      low_ff <= DSF_RST_LOW;
      mid_ff <= DSF_RST_MID;
      rd_data_ff <= 8'h00;
    end else begin
      low_ff <= nxt_low;
      mid_ff <= nxt_mid;
      rd_data_ff <= nxt_rd_data;
    end
  end

  assign rd_data = rd_data_ff;
  assign rd_hit = rd_data_en;
  assign diagnostic_word = {mid_ff, low_ff}; // see (RULE10) (RULE11)

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A read with no live condition must leave the register empty.
  low_cleared_a: assert property ( // see (RULE1)
    @(posedge core_clk) disable iff (!rst_n)
    rd_low && set_low == 8'h00 |=> low_ff == 8'h00)
    else $error("low register not cleared by read");

  mid_cleared_a: assert property ( // see (RULE9)
    @(posedge core_clk) disable iff (!rst_n)
    rd_mid && set_mid == 8'h00 |=> mid_ff == 8'h00)
    else $error("mid register not cleared by read");

  read_data_a: assert property ( // see (RULE10)
    @(posedge core_clk) disable iff (!rst_n)
    rd_low |=> rd_data == $past(low_ff))
    else $error("read data does not match low register");

  read_mid_a: assert property ( // see (RULE11)
    @(posedge core_clk) disable iff (!rst_n)
    rd_mid |=> rd_data == $past(mid_ff))
    else $error("read data does not match mid register");

  // A refused address must not disturb the last answer.
  refused_read_a: assert property ( // see (RULE13)
    @(posedge core_clk) disable iff (!rst_n)
    !rd_hit |=> rd_data == $past(rd_data))
    else $error("read data changed without a hit");

  sticky_low_a: assert property ( // see (RULE3)
    @(posedge core_clk) disable iff (!rst_n)
    !rd_low && low_ff[2] |=> low_ff[2])
    else $error("shutdown flag lost without read");

  sticky_mid_a: assert property ( // see (RULE8)
    @(posedge core_clk) disable iff (!rst_n)
    !rd_mid && mid_ff[0] |=> mid_ff[0])
    else $error("stuck flag lost without read");

  set_wins_a: assert property ( // see (RULE14)
    @(posedge core_clk) disable iff (!rst_n)
    rd_low && ev_ff.remote_wakeup |=> low_ff[6])
    else $error("wakeup lost on clearing read");

  reserved_a: assert property ( // see (RULE11)
    @(posedge core_clk) disable iff (!rst_n)
    low_ff[5] == 1'b0 && mid_ff[7:2] == 6'h00)
    else $error("reserved bit set");

  // Each live, synchronised condition must show one cycle later.
  por_set_a: assert property ( // see (RULE1)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.supply_por |=> low_ff[0])
    else $error("power-on flag not set");

  uv_set_a: assert property ( // see (RULE2)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.regulator_undervoltage |=> low_ff[1])
    else $error("undervoltage flag not set");

  shutdown_set_a: assert property ( // see (RULE3)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.overtemp_shutdown |=> low_ff[2])
    else $error("shutdown flag not set");

  warn_set_a: assert property ( // see (RULE4)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.overtemp_warning |=> low_ff[3])
    else $error("warning flag not set");

  overvolt_set_a: assert property ( // see (RULE5)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.battery_overvoltage |=> low_ff[4])
    else $error("overvoltage flag not set");

  wakeup_set_a: assert property ( // see (RULE6)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.remote_wakeup |=> low_ff[6])
    else $error("wakeup flag not set");

  watchdog_set_a: assert property ( // see (RULE7)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.window_watchdog_timeout |=> low_ff[7])
    else $error("watchdog flag not set");

  tx_stuck_a: assert property ( // see (RULE8)
    @(posedge core_clk) disable iff (!rst_n)
    !tx_ff |=> !tx_stuck)
    else $error("transmit stuck without low line");

  stuck_set_a: assert property ( // see (RULE8)
    @(posedge core_clk) disable iff (!rst_n)
    tx_stuck |=> mid_ff[0])
    else $error("stuck flag not set");

  temporary_shutdown_flag_a: assert property ( // see (RULE9)
    @(posedge core_clk) disable iff (!rst_n)
    ev_ff.temporary_shutdown_entry |=> mid_ff[1])
    else $error("shutdown entry flag not set");
endmodule

/* dsf_host.sv */
// Host model that starts register reads on the flag bank's read port.
// Assumes the bench calls read from a single process at a time.
`timescale 1ns/1ps
module dsf_host (
  input wire logic core_clk,
  output dsf_pkg::dsf_rd_s rd,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  import dsf_pkg::*;
  // A warning flag found set after a hot start is taken as real.
  initial begin
    rd = '0;
  end
  // The strobe stands one cycle; a released address shows its inverse.
  task automatic read(input logic [4:0] a, output logic [7:0] d,
                      output logic h);
    @(posedge core_clk);
    rd <= '{read_stb: 1'b1, addr: a};
    @(posedge core_clk);
    h = rd_hit;
    rd <= '{read_stb: 1'b0, addr: ~a};
    @(posedge core_clk);
    d = rd_data;
  endtask
endmodule

/* tb_diagnostic_status_flags.sv */
// Self-checking bench for the diagnostic flag bank.
// Assumes the host model and a shortened transmit-stuck count.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %0t value mismatch", $time); end end
module tb_diagnostic_status_flags;
  import dsf_pkg::*;
  localparam longint STUCK = 20;
  logic core_clk = 0;
  logic rst_n = 0;
  dsf_events_s events_async = '0;
  logic transmit_low_async = 0;
  dsf_rd_s rd;
  logic [7:0] rd_data;
  logic rd_hit;
  logic [15:0] diagnostic_word;
  int failures = 0;
  int samples_checked = 0;
  always #5 core_clk = ~core_clk;
  dsf_flags #(.TX_STUCK_CYC(STUCK)) dut_u (.core_clk(core_clk),
    .rst_n(rst_n), .events_async(events_async),
    .transmit_low_async(transmit_low_async), .rd(rd), .rd_data(rd_data),
    .rd_hit(rd_hit), .diagnostic_word(diagnostic_word));
  dsf_host host_u (.core_clk(core_clk), .rd(rd), .rd_data(rd_data),
    .rd_hit(rd_hit));
  task automatic rc(input logic [4:0] a, input logic [7:0] e,
                    input logic eh);
    logic [7:0] d;
    logic h;
    host_u.read(a, d, h);
    `CHK(h, eh)
    `CHK(d, e)
  endtask
  task automatic t_reset();
    `CHK(diagnostic_word, 16'h0003)
    rc(DSF_ADDR_LOW, 8'h03, 1'b1);
    rc(DSF_ADDR_LOW, 8'h00, 1'b1);
    rc(DSF_ADDR_MID, 8'h00, 1'b1);
    rc(5'h0A, 8'h00, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_events();
    logic [7:0] ex [8] = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02,
                           8'h01, 8'h02};
    logic [15:0] w;
    logic [4:0] a;
    for (int i = 0; i < 8; i++) begin
      events_async <= dsf_events_s'(8'h80 >> i);
      w = (i < 7) ? {8'h00, ex[i]} : {ex[i], 8'h00};
      a = (i < 7) ? DSF_ADDR_LOW : DSF_ADDR_MID;
      @(posedge core_clk);
      events_async <= '0;
      repeat (4) @(posedge core_clk);
      `CHK(diagnostic_word, w)
      rc(a, ex[i], 1'b1);
      rc(a, 8'h00, 1'b1);
      rc(5'h1F, 8'h00, 1'b0);
    end
    $display("test events done");
  endtask
  task automatic t_held();
    events_async <= dsf_events_s'(8'h10);
    repeat (4) @(posedge core_clk);
    rc(DSF_ADDR_LOW, 8'h08, 1'b1);
    rc(DSF_ADDR_LOW, 8'h08, 1'b1);
    events_async <= '0;
    repeat (4) @(posedge core_clk);
    rc(DSF_ADDR_LOW, 8'h08, 1'b1);
    rc(DSF_ADDR_LOW, 8'h00, 1'b1);
    $display("test held done");
  endtask
  task automatic t_hot();
    events_async <= '{overtemp_warning: 1'b1, default: 1'b0};
    rst_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK(diagnostic_word, 16'h0003)
    repeat (3) @(posedge core_clk);
    rc(DSF_ADDR_LOW, 8'h0B, 1'b1);
    rc(DSF_ADDR_LOW, 8'h08, 1'b1);
    events_async <= '0;
    repeat (4) @(posedge core_clk);
    rc(DSF_ADDR_LOW, 8'h08, 1'b1);
    rc(DSF_ADDR_LOW, 8'h00, 1'b1);
    $display("test hot start done");
  endtask
  task automatic t_stuck(input int n, input logic [7:0] e);
    transmit_low_async <= 1'b1;
    repeat (n) @(posedge core_clk);
    transmit_low_async <= 1'b0;
    repeat (5) @(posedge core_clk);
    rc(DSF_ADDR_MID, e, 1'b1);
    rc(DSF_ADDR_MID, 8'h00, 1'b1);
    $display("test stuck done");
  endtask
  task automatic summarize();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #50000;
    failures++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_events();
    t_held();
    t_hot();
    t_stuck(int'(STUCK), 8'h00);
    t_stuck(int'(STUCK) + 1, 8'h01);
    summarize();
  end
endmodule
